// [test/uer_peer.sv]
// Purpose: Serial peer that clocks frames into the transceiver pins
// Assumes: Caller picks the half period; serial clock idles low
// Notes: Data line shows the inverse of its last bit once released
module uer_peer (
  output logic sclk_pin, // Serial clock, still between frames
  output logic cs_n_pin, // Select, active low
  output logic mosi_pin // Data, MSB first
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // Idle levels
  initial begin
    sclk_pin = 1'b0;
    cs_n_pin = 1'b1;
    mosi_pin = 1'b1;
  end

  // One frame of nbits; half must keep the clock 9x slower than core
  // A fast half is passed by the SPI and ratio scenarios; only sync mode checks it
  task automatic frame(input int nbits, input logic [8:0] bits, input int half,
                       input logic sel);
    cs_n_pin = ~sel;
    #(half);
    for (int i = 0; i < nbits; i++) begin
      mosi_pin = bits[nbits-1-i];
      #(half);
      sclk_pin = 1'b1;
      #(half);
      sclk_pin = 1'b0;
    end
    mosi_pin = ~mosi_pin; // Released line must not look valid
    #(half);
    cs_n_pin = 1'b1;
  endtask
endmodule // uer_peer

// [test/usart_errata_behaviour_test.sv]
// Purpose: Self-checking bench for the serial transceiver model
// Assumes: Inputs change on the falling edge; pins come from uer_peer
// Notes: Pulses are caught by a monitor so tasks can check them later
module usart_errata_behaviour_test;
  import uer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, reset, mode_write, ctrl_write, rx_enable, rx_soft_reset;
  logic hi, lo, dma_rx_full, tx_char_done, iso_rx_strobe;
  uer_mode_t mode_sel;
  wire sclk, cs_n, mosi;
  logic [7:0] err_count, rx_data;
  logic accept, locked, rts_n, rx_valid, rx_corrupt, ol_err, ratio_err;
  logic rx_seen, ol_seen, ratio_seen;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  uer_peer u_peer (.sclk_pin(sclk), .cs_n_pin(cs_n), .mosi_pin(mosi));
  uer_core u_dut (.clk(clk), .reset(reset), .mode_sel(mode_sel), .mode_write(mode_write),
    .ctrl_write(ctrl_write), .rx_enable(rx_enable), .rx_soft_reset(rx_soft_reset),
    .rts_force_high_cmd(hi), .rts_force_low_cmd(lo), .dma_rx_full(dma_rx_full),
    .tx_char_done(tx_char_done), .iso_rx_strobe(iso_rx_strobe), .sclk_pin(sclk),
    .cs_n_pin(cs_n), .mosi_pin(mosi), .iso_error_counter(err_count), .iso_rx_accept(accept),
    .t1_rx_locked(locked), .rts_n(rts_n), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_corrupt(rx_corrupt), .overlength_err(ol_err), .clk_ratio_err(ratio_err));

  // ==========================================
  // Clock, pulse catcher and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rx_valid) rx_seen <= 1'b1;
    if (ol_err) ol_seen <= 1'b1;
    if (ratio_err) ratio_seen <= 1'b1;
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      results();
    end
  end

  // ==========================================
  // Shared helpers
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rx_frame(input int n, input logic [8:0] b, input int half, input logic sel);
    rx_seen = 1'b0;
    u_peer.frame(n, b, half, sel);
    step(6);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_rts();
    mode_sel = UER_MODE_NORMAL;
    pulse(hi);
    step(2);
    chk("rts forced high", 8'h01, {7'h0, rts_n});
    step(3);
    chk("rts after zero writes", 8'h01, {7'h0, rts_n});
    pulse(lo);
    step(2);
    chk("rts forced low", 8'h00, {7'h0, rts_n});
    mode_sel = UER_MODE_HANDSHAKE;
    dma_rx_full = 1'b1;
    pulse(hi);
    step(3);
    chk("rts in handshake", 8'h00, {7'h0, rts_n});
    dma_rx_full = 1'b0;
    $display("test rts done");
  endtask

  task automatic t_lock();
    mode_sel = UER_MODE_ISO_T1;
    pulse(tx_char_done);
    step(2);
    chk("locked after tx", 8'h01, {7'h0, locked});
    // Strobe held over one edge so it changes only on falling edges
    iso_rx_strobe = 1'b1;
    step(1);
    chk("accept while locked", 8'h00, {7'h0, accept});
    iso_rx_strobe = 1'b0;
    pulse(ctrl_write);
    pulse(rx_soft_reset);
    pulse(mode_write);
    pulse(ctrl_write);
    step(2);
    chk("locked after recovery", 8'h00, {7'h0, locked});
    iso_rx_strobe = 1'b1;
    step(1);
    chk("accept after recovery", 8'h01, {7'h0, accept});
    iso_rx_strobe = 1'b0;
    chk("error counter", 8'h00, err_count);
    $display("test lockout done");
  endtask

  task automatic t_spi();
    mode_sel = UER_MODE_SPI_SLAVE;
    rx_frame(8, 9'h0A5, 40, 1'b1);
    chk("spi delivered", 8'h01, {7'h0, rx_seen});
    chk("spi data", 8'hA5, rx_data);
    ol_seen = 1'b0;
    rx_frame(9, 9'h14B, 40, 1'b1);
    chk("overlength flag", 8'h01, {7'h0, ol_seen});
    rx_enable = 1'b0;
    pulse(rx_soft_reset);
    rx_enable = 1'b1;
    rx_frame(8, 9'h0A5, 40, 1'b1);
    chk("data after overlength", 8'h4B, rx_data);
    chk("corrupt mark", 8'h01, {7'h0, rx_corrupt});
    rx_frame(8, 9'h03C, 40, 1'b1);
    chk("clean data", 8'h3C, rx_data);
    chk("clean mark", 8'h00, {7'h0, rx_corrupt});
    chk("error counter", 8'h00, err_count);
    $display("test spi done");
  endtask

  task automatic t_ratio();
    mode_sel = UER_MODE_SYNC_SLAVE;
    ratio_seen = 1'b0;
    rx_frame(8, 9'h055, 60, 1'b0);
    chk("slow clock flag", 8'h00, {7'h0, ratio_seen});
    chk("sync data", 8'h55, rx_data);
    rx_frame(8, 9'h0C3, 40, 1'b0);
    chk("fast clock flag", 8'h01, {7'h0, ratio_seen});
    $display("test ratio done");
  endtask

  // ==========================================
  // Verdict
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    mode_sel = UER_MODE_NORMAL;
    {mode_write, ctrl_write, rx_soft_reset, hi, lo} = 5'h0;
    {dma_rx_full, tx_char_done, iso_rx_strobe} = 3'h0;
    rx_enable = 1'b1;
    {rx_seen, ol_seen, ratio_seen} = 3'h0;
    step(4);
    reset = 1'b0;
    step(1);
    chk("error counter at reset", 8'h00, err_count);
    t_rts();
    t_lock();
    t_spi();
    t_ratio();
    results();
  end
endmodule // usart_errata_behaviour_test

// [verilog/uer_core.sv]
// Purpose: Serial transceiver model with its known faulty behaviours
// Assumes: Strobe inputs come from logic on clk; pins are asynchronous
// Notes: Receiver shifts MSB first on serial clock rise
// What this block does
// - Error counter read returns zero always, regardless of errors.
// - T1 mode: after any transmit, receive locks until reset, mode, control rewrite.
// - Handshake mode keeps request-to-send low even when DMA buffer fills.
// - Normal mode: force-high command drives request-to-send high.
// - Force-low command drives request-to-send low again.
// - SPI slave over-length frame flags error and corrupts next reception.
module uer_core (
  input wire logic clk, // Core clock, 100 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire uer_pkg::uer_mode_t mode_sel, // Operating mode from mode register
  input wire logic mode_write, // Pulse: mode register written
  input wire logic ctrl_write, // Pulse: control register written
  input wire logic rx_enable, // Receiver enabled level
  input wire logic rx_soft_reset, // Pulse: receiver soft reset
  input wire logic rts_force_high_cmd, // Pulse: force request-to-send high
  input wire logic rts_force_low_cmd, // Pulse: force request-to-send low
  input wire logic dma_rx_full, // DMA receive buffer full level
  input wire logic tx_char_done, // Pulse: a character was transmitted
  input wire logic iso_rx_strobe, // Pulse: smart-card character received
  input wire logic sclk_pin, // Serial clock pin
  input wire logic cs_n_pin, // Slave select pin, active low
  input wire logic mosi_pin, // Serial data pin
  output logic [7:0] iso_error_counter, // Error counter read value
  output logic iso_rx_accept, // Smart-card character accepted
  output logic t1_rx_locked, // Receive locked out in T1 mode
  output logic rts_n, // Request-to-send pin, active low
  output logic [7:0] rx_data, // Received character
  output logic rx_valid, // Pulse: rx_data is new
  output logic rx_corrupt, // Received character is damaged
  output logic overlength_err, // Pulse: frame had too many bits
  output logic clk_ratio_err // Pulse: external clock too fast
);
  import uer_pkg::*;

  logic sclk_rise, cs_n_rise, cs_n_sync, mosi_sync;

  // ==========================================================
  // Pin synchronisation
  uer_pin_sync u_sync (
    .clk(clk),
    .reset(reset),
    .sclk_pin(sclk_pin),
    .cs_n_pin(cs_n_pin),
    .mosi_pin(mosi_pin),
    .sclk_rise(sclk_rise),
    .cs_n_rise(cs_n_rise),
    .cs_n_sync(cs_n_sync),
    .mosi_sync(mosi_sync)
  );

  // ==========================================================
  // Error counter: the counter never reaches the read path
  logic [7:0] errcnt_ff, nxt_errcnt;

  always_comb begin
    nxt_errcnt = UER_ERRCNT_VALUE;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      errcnt_ff <= UER_ERRCNT_VALUE;
    end else begin
      errcnt_ff <= nxt_errcnt;
    end
  end

  assign iso_error_counter = errcnt_ff;

  // ==========================================================
  // T1 receive lockout and its recovery sequence
  uer_lock_t lock_ff, nxt_lock;

  // Only core reset or the ordered soft reset, mode write, control write reopens reception
  always_comb begin
    nxt_lock = lock_ff;
    case (lock_ff)
      UER_LK_OPEN: begin
        if (mode_sel == UER_MODE_ISO_T1 && tx_char_done) begin
          nxt_lock = UER_LK_LOCKED;
        end
      end
      UER_LK_LOCKED: begin
        if (rx_soft_reset) begin
          nxt_lock = UER_LK_RST_SEEN;
        end
      end
      UER_LK_RST_SEEN: begin
        if (tx_char_done) begin
          nxt_lock = UER_LK_LOCKED;
        end else if (mode_write) begin
          nxt_lock = UER_LK_MODE_SEEN;
        end
      end
      UER_LK_MODE_SEEN: begin
        if (tx_char_done) begin
          nxt_lock = UER_LK_LOCKED;
        end else if (ctrl_write) begin
          nxt_lock = UER_LK_OPEN;
        end
      end
      default: begin
        nxt_lock = UER_LK_OPEN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lock_ff <= UER_LK_OPEN;
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  assign t1_rx_locked = (lock_ff != UER_LK_OPEN);
  assign iso_rx_accept = iso_rx_strobe & ~t1_rx_locked & rx_enable;

  // ==========================================================
  // Request-to-send; low wins if both commands land together
  logic rts_ff, nxt_rts;

  // Handshake mode ignores the buffer-full level, which is the fault
  always_comb begin
    nxt_rts = rts_ff;
    if (mode_sel == UER_MODE_HANDSHAKE) begin
      nxt_rts = 1'b0;
    end else if (rts_force_low_cmd) begin
      nxt_rts = 1'b0;
    end else if (rts_force_high_cmd && mode_sel == UER_MODE_NORMAL) begin
      nxt_rts = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rts_ff <= UER_RTS_N_RST;
    end else begin
      rts_ff <= nxt_rts;
    end
  end

  assign rts_n = rts_ff;

  // ==========================================================
  // Slave receiver: SPI slave framed by select, sync slave free-running
  logic [7:0] shift_ff, nxt_shift;
  logic [3:0] bits_ff, nxt_bits;
  logic pend_ff, nxt_pend;
  logic [7:0] data_ff, nxt_data;
  logic valid_ff, nxt_valid, corrupt_ff, nxt_corrupt, ovl_ff, nxt_ovl;
  logic spi_mode, sync_mode, take_bit;

  assign spi_mode = (mode_sel == UER_MODE_SPI_SLAVE);
  assign sync_mode = (mode_sel == UER_MODE_SYNC_SLAVE);
  assign take_bit = rx_enable & sclk_rise & ((spi_mode & ~cs_n_sync) | sync_mode);

  // Damage flag survives disable and soft reset; core reset or the next completed character clears it
  always_comb begin
    nxt_shift = shift_ff;
    nxt_bits = bits_ff;
    nxt_pend = pend_ff;
    nxt_data = data_ff;
    nxt_valid = 1'b0;
    nxt_corrupt = corrupt_ff;
    nxt_ovl = 1'b0;
    if (rx_soft_reset || (spi_mode && cs_n_rise)) begin
      nxt_shift = UER_DATA_RST;
      nxt_bits = UER_CNT_RST;
    end else if (take_bit) begin
      nxt_shift = {shift_ff[6:0], mosi_sync};
      if (bits_ff == UER_CHAR_LAST) begin
        nxt_valid = 1'b1;
        nxt_corrupt = pend_ff;
        nxt_pend = 1'b0;
        // A damaged character arrives one bit out of alignment
        nxt_data = pend_ff ? {shift_ff[5:0], mosi_sync, shift_ff[6]} :
                             {shift_ff[6:0], mosi_sync};
        nxt_bits = sync_mode ? UER_CNT_RST : bits_ff + 4'h1;
      end else if (bits_ff > UER_CHAR_LAST) begin
        if (bits_ff == UER_CHAR_LAST + 4'h1) begin
          nxt_ovl = 1'b1;
          nxt_pend = 1'b1;
        end
        if (bits_ff != UER_CNT_MAX) begin
          nxt_bits = bits_ff + 4'h1;
        end
      end else begin
        nxt_bits = bits_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      shift_ff <= UER_DATA_RST;
      bits_ff <= UER_CNT_RST;
      pend_ff <= 1'b0;
      data_ff <= UER_DATA_RST;
      valid_ff <= 1'b0;
      corrupt_ff <= 1'b0;
      ovl_ff <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      bits_ff <= nxt_bits;
      pend_ff <= nxt_pend;
      data_ff <= nxt_data;
      valid_ff <= nxt_valid;
      corrupt_ff <= nxt_corrupt;
      ovl_ff <= nxt_ovl;
    end
  end

  assign rx_data = data_ff;
  assign rx_valid = valid_ff;
  assign rx_corrupt = corrupt_ff;
  assign overlength_err = ovl_ff;

  // ==========================================================
  // External clock period check; zero count means no edge seen yet
  logic [3:0] per_ff, nxt_per;
  logic rerr_ff, nxt_rerr;

  always_comb begin
    nxt_per = per_ff;
    nxt_rerr = 1'b0;
    if (!sync_mode) begin
      nxt_per = UER_CNT_RST;
    end else if (sclk_rise) begin
      nxt_rerr = (per_ff != UER_CNT_RST) && (per_ff < UER_MIN_CLK_RATIO);
      nxt_per = UER_RATIO_START;
    end else if (per_ff != UER_CNT_RST && per_ff != UER_CNT_MAX) begin
      nxt_per = per_ff + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      per_ff <= UER_CNT_RST;
      rerr_ff <= 1'b0;
    end else begin
      per_ff <= nxt_per;
      rerr_ff <= nxt_rerr;
    end
  end

  assign clk_ratio_err = rerr_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  errcnt_zero_a: assert property (iso_error_counter == UER_ERRCNT_VALUE)
    else $error("error counter read not zero");
  t1_lock_a: assert property (mode_sel == UER_MODE_ISO_T1 && tx_char_done |=> t1_rx_locked)
    else $error("T1 transmit did not lock receive");
  t1_block_a: assert property (t1_rx_locked |-> !iso_rx_accept)
    else $error("character accepted while locked");
  hs_rts_a: assert property (mode_sel == UER_MODE_HANDSHAKE ##1 dma_rx_full |-> !rts_n)
    else $error("handshake request-to-send not low");
  force_high_a: assert property (mode_sel == UER_MODE_NORMAL && rts_force_high_cmd
      && !rts_force_low_cmd |=> rts_n)
    else $error("force high did not raise request-to-send");
  force_low_a: assert property (rts_force_low_cmd |=> !rts_n)
    else $error("force low did not lower request-to-send");
  rts_hold_a: assert property (!rts_force_high_cmd && !rts_force_low_cmd
      && mode_sel != UER_MODE_HANDSHAKE |=> $stable(rts_n))
    else $error("request-to-send moved without a command");
  ovl_mark_a: assert property (overlength_err |-> pend_ff && !rx_valid)
    else $error("over-length frame not remembered");
  corrupt_next_a: assert property (pend_ff && take_bit && bits_ff == UER_CHAR_LAST
      |=> rx_valid && rx_corrupt)
    else $error("next character after over-length not marked");

endmodule // uer_core

// [verilog/uer_pin_sync.sv]
// Purpose: Two-stage synchroniser for serial clock, select and data pins
// Assumes: Pins are asynchronous to clk
// Notes: First stage feeds only the second; edges come from later stages
module uer_pin_sync (
  input wire logic clk, // Core clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic sclk_pin, // Serial clock pin
  input wire logic cs_n_pin, // Slave select pin, active low
  input wire logic mosi_pin, // Serial data pin
  output logic sclk_rise, // One-cycle pulse on serial clock rise
  output logic cs_n_rise, // One-cycle pulse at end of select
  output logic cs_n_sync, // Synchronised select level
  output logic mosi_sync // Synchronised data level
);

  logic [2:0] meta_ff, nxt_meta;
  logic [2:0] sync_ff, nxt_sync;
  logic [1:0] prev_ff, nxt_prev;

  // ==========================================================
  // Next values: meta -> sync -> previous copy for edge detection
  always_comb begin
    nxt_meta = {sclk_pin, cs_n_pin, mosi_pin};
    nxt_sync = meta_ff;
    nxt_prev = sync_ff[2:1];
  end

  // Registers; select idles high so no false edge after reset
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_ff <= 3'b010;
      sync_ff <= 3'b010;
      prev_ff <= 2'b01;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  assign sclk_rise = sync_ff[2] & ~prev_ff[1];
  assign cs_n_rise = sync_ff[1] & ~prev_ff[0];
  assign cs_n_sync = sync_ff[1];
  assign mosi_sync = sync_ff[0];

endmodule // uer_pin_sync

// [verilog/uer_pkg.sv]
// Purpose: Shared constants and types for the serial transceiver model
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes: Mode and lockout encodings are sequential from zero in declaration order
package uer_pkg;

  // ==========================================================
  // Character framing
  localparam int unsigned UER_CHAR_BITS = 8;
  localparam logic [3:0] UER_CHAR_LAST = 4'h7;
  localparam logic [3:0] UER_CNT_MAX = 4'hF;

  // ==========================================================
  // Reset values
  localparam logic [7:0] UER_ERRCNT_VALUE = 8'h00;
  localparam logic [7:0] UER_DATA_RST = 8'h00;
  localparam logic [3:0] UER_CNT_RST = 4'h0;
  localparam logic UER_RTS_N_RST = 1'b0;

  // ==========================================================
  // External clock must be this many internal clocks per period, at least
  localparam logic [3:0] UER_MIN_CLK_RATIO = 4'h9;
  localparam logic [3:0] UER_RATIO_START = 4'h1;

  // ==========================================================
  // Operating modes
  typedef enum logic [2:0] {
    UER_MODE_NORMAL,
    UER_MODE_HANDSHAKE,
    UER_MODE_ISO_T1,
    UER_MODE_SPI_SLAVE,
    UER_MODE_SYNC_SLAVE
  } uer_mode_t;

  // Receive lockout recovery sequence
  typedef enum logic [1:0] {
    UER_LK_OPEN,
    UER_LK_LOCKED,
    UER_LK_RST_SEEN,
    UER_LK_MODE_SEEN
  } uer_lock_t;

endpackage
